// [core/sfdp_parameter_read.sv]
// Device-side handler for the discoverable-parameter table read command
`timescale 1ns/10ps
module sfdp_parameter_read #(
  parameter int TABLE_AW   = sfdp_pkg::TABLE_AW,
  parameter int FIFO_DEPTH = sfdp_pkg::FIFO_DEPTH
) (
  input  wire logic sys_clk,    // 200 MHz system clock
  input  wire logic sys_rst,    // Synchronous reset, high
  input  wire logic sel_n,      // Chip select, low active
  input  wire logic spi_clk,    // Serial clock, sampled
  input  wire logic spi_di,     // Serial data in
  input  wire logic flash_busy, // Erase/program/write running
  output logic      spi_do,     // Serial data out
  output logic      spi_do_oe,  // High while driving spi_do
  output logic      refused     // Last command ignored as busy
);
  import sfdp_pkg::*;

  cmd_state_t            state;
  logic                  sclk_q;
  logic                  rise;
  logic                  fall;
  logic [5:0]            bit_cnt;
  logic [ADDR_BITS-1:0]  shift_in;
  logic [ADDR_BITS-1:0]  next_shift;
  logic                  last_bit;
  logic                  cmd_done;
  logic                  addr_done;
  logic [TABLE_AW-1:0]   fetch_addr;
  logic                  fetch_en;
  logic [7:0]            out_shift;
  logic [2:0]            out_cnt;
  logic                  byte_start;

  byte_stream_if #(.W(8)) fill ();
  byte_stream_if #(.W(8)) drain ();

  // Edges of the sampled serial clock, only while selected
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_clk;
    end
  end

  assign rise       = !sel_n && spi_clk && !sclk_q;
  assign fall       = !sel_n && !spi_clk && sclk_q;
  assign next_shift = {shift_in[ADDR_BITS-2:0], spi_di};

  // Phase end detection per state
  always_comb begin
    unique case (state)
      ST_CMD:   last_bit = (bit_cnt == 6'(CMD_BITS - 1));
      ST_ADDR:  last_bit = (bit_cnt == 6'(ADDR_BITS - 1));
      ST_DUMMY: last_bit = (bit_cnt == 6'(DUMMY_BITS - 1));
      default:  last_bit = 1'b0;
    endcase
  end

  assign cmd_done  = rise && (state == ST_CMD) && last_bit;
  assign addr_done = rise && (state == ST_ADDR) && last_bit;

  // Input bits land on the rising serial edge, MSB first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_in <= '0;
    end else if (rise) begin
      shift_in <= next_shift;
    end
  end

  // Command sequencer; deselect drops any partial command
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sel_n) begin
      state   <= ST_CMD;
      bit_cnt <= BIT_CNT_RESET;
    end else if (rise) begin
      bit_cnt <= last_bit ? BIT_CNT_RESET : bit_cnt + 1'b1;
      unique case (state)
        ST_CMD: begin
          if (last_bit) begin
            // Busy flash: command swallowed, only the refused flag is set
            if (next_shift[7:0] == OPCODE_PARAM_READ && !flash_busy) begin
              state <= ST_ADDR;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          if (last_bit) begin
            state <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (last_bit) begin
            state <= ST_DATA;
          end
        end
        ST_DATA, ST_IGNORE: begin
          state <= state;
        end
      endcase
    end
  end

  // Status of the last decoded command
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refused <= 1'b0;
    end else if (cmd_done) begin
      refused <= (next_shift[7:0] == OPCODE_PARAM_READ) && flash_busy;
    end
  end

  // Prefetch from the end of the address phase; the dummy byte gives
  // the FIFO eight serial clocks of head start before the first byte.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sel_n) begin
      fetch_en   <= 1'b0;
      fetch_addr <= '0;
    end else if (addr_done) begin
      fetch_en   <= 1'b1;
      fetch_addr <= next_shift[TABLE_AW-1:0];
    end else if (fill.valid && fill.ready) begin
      // Natural overflow of the top address returns to zero
      fetch_addr <= fetch_addr + 1'b1;
    end
  end

  assign fill.valid = fetch_en;
  assign fill.data  = table_byte(fetch_addr);

  // Byte buffer; a full FIFO stalls the fetcher
  byte_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (sys_clk),
    .rst   (sys_rst),
    .flush (sel_n),
    .fill  (fill),
    .drain (drain)
  );

  assign byte_start  = fall && (state == ST_DATA) && (out_cnt == 3'h0);
  assign drain.ready = byte_start;

  // Output shifter; bits change on the falling serial edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_do    <= 1'b0;
      out_shift <= '0;
      out_cnt   <= OUT_CNT_RESET;
    end else if (sel_n) begin
      out_cnt <= OUT_CNT_RESET;
    end else if (fall && state == ST_DATA) begin
      out_cnt <= out_cnt + 1'b1;
      if (out_cnt == 3'h0) begin
        // Serial clock too fast for the fetcher: fill byte goes out
        spi_do    <= drain.valid ? drain.data[7] : FILL_BYTE[7];
        out_shift <= drain.valid ? {drain.data[6:0], 1'b1} : FILL_BYTE;
      end else begin
        spi_do    <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b1};
      end
    end
  end

  // Drive enable follows the data phase, dropped at once on deselect
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sel_n) begin
      spi_do_oe <= 1'b0;
    end else if (fall && state == ST_DATA) begin
      spi_do_oe <= 1'b1;
    end
  end

  // Checks
  opcode_accept_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_done && next_shift[7:0] == OPCODE_PARAM_READ && !flash_busy
    |=> state == ST_ADDR)
    else $error("read opcode not accepted");

  foreign_op_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_done && next_shift[7:0] != OPCODE_PARAM_READ
    |=> state == ST_IGNORE && !refused)
    else $error("foreign opcode not ignored");

  addr_capture_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    addr_done
    |=> fetch_en && fetch_addr == $past(next_shift[TABLE_AW-1:0]))
    else $error("start address not captured");

  data_entry_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_DUMMY && last_bit
    |=> state == ST_DATA)
    else $error("data phase not entered after dummy byte");

  fall_only_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $changed(spi_do)
    |-> $past(fall) || $past(sys_rst))
    else $error("data changed away from a falling edge");

  out_first_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    byte_start && drain.valid
    |=> spi_do == $past(drain.data[7]) && spi_do_oe)
    else $error("first bit of a byte not driven");

  addr_step_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fill.ready && !sel_n
    |=> fetch_addr == TABLE_AW'($past(fetch_addr) + 1'b1))
    else $error("address did not advance by one");

  addr_wrap_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fill.ready && !sel_n && fetch_addr == '1
    |=> fetch_addr == '0)
    else $error("address did not wrap to zero");

  deselect_idle_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    sel_n
    |=> !spi_do_oe && state == ST_CMD && !fill.valid)
    else $error("deselect did not return to idle");

  // Foreign opcodes while busy are covered by foreign_op_a
  busy_ignore_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_done && flash_busy && next_shift[7:0] == OPCODE_PARAM_READ
    |=> state == ST_IGNORE && refused ##1 !spi_do_oe [*3])
    else $error("command accepted while busy");

  // Table contents as handed to the FIFO
  sig_head_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h00)
    |-> fill.data == 8'h53)
    else $error("signature byte wrong");

  sig_tail_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h03)
    |-> fill.data == 8'h50)
    else $error("last signature byte wrong");

  minor_rev_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h04)
    |-> fill.data == 8'h00)
    else $error("minor revision byte wrong");

  major_rev_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h05)
    |-> fill.data == 8'h01)
    else $error("major revision byte wrong");

  hdr_count_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h06)
    |-> fill.data == 8'h00)
    else $error("header count byte wrong");

  reserved_fill_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && (fetch_addr == TABLE_AW'(8'h07) ||
                   fetch_addr == TABLE_AW'(8'h0f))
    |-> fill.data == 8'hff)
    else $error("reserved byte wrong");

  header_id_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h08)
    |-> fill.data == 8'h00)
    else $error("parameter header id wrong");

  header_minor_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h09)
    |-> fill.data == 8'h00)
    else $error("parameter header minor revision wrong");

  header_major_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h0a)
    |-> fill.data == 8'h01)
    else $error("parameter header major revision wrong");

  length_byte_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h0b)
    |-> fill.data == 8'h09)
    else $error("table length byte wrong");

  pointer_low_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fetch_addr == TABLE_AW'(8'h0c)
    |-> fill.data == 8'h30)
    else $error("table pointer byte wrong");

  pointer_high_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill.valid && (fetch_addr == TABLE_AW'(8'h0d) ||
                   fetch_addr == TABLE_AW'(8'h0e))
    |-> fill.data == 8'h00)
    else $error("table pointer upper byte wrong");

  read_start_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    byte_start && drain.valid);

  wrap_seen_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    fill.valid && fill.ready && fetch_addr == '1);

  busy_refused_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_done && flash_busy);

  mid_abort_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    spi_do_oe ##1 sel_n);

endmodule : sfdp_parameter_read

// [core/sfdp_pkg.sv]
// Constants, types and header table for the parameter-table read block
package sfdp_pkg;

  localparam logic [7:0] OPCODE_PARAM_READ = 8'h5a;
  localparam int         CMD_BITS          = 8;
  localparam int         ADDR_BITS         = 24;
  localparam int         DUMMY_BITS        = 8;
  localparam int         TABLE_AW          = 8;
  localparam int         FIFO_DEPTH        = 8;
  localparam int         HEADER_BYTES      = 16;
  localparam logic [7:0] FILL_BYTE         = 8'hff;
  localparam logic [5:0] BIT_CNT_RESET     = 6'h00;
  localparam logic [2:0] OUT_CNT_RESET     = 3'h0;

  // Header table, byte address order
  localparam logic [7:0] HEADER_TABLE [HEADER_BYTES] = '{
    8'h53, 8'h46, 8'h44, 8'h50,  // Signature
    8'h00, 8'h01,                // Revision
    8'h00, 8'hff,                // header_count_field, reserved
    8'h00, 8'h00, 8'h01,         // First header ID, minor and major revision
    8'h09,                       // Length in words
    8'h30, 8'h00, 8'h00,         // table_pointer_field
    8'hff                        // Reserved
  };

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } cmd_state_t;

  // Table byte at an address; the basic table body reads as fill
  function automatic logic [7:0] table_byte(input logic [TABLE_AW-1:0] a);
    if (a < TABLE_AW'(HEADER_BYTES))
      return HEADER_TABLE[a[3:0]];
    return FILL_BYTE;
  endfunction : table_byte

endpackage : sfdp_pkg

// [core/byte_stream_if.sv]
// Valid/ready byte stream between the fetcher, the FIFO and the shifter
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// [core/byte_fifo.sv]
// Synchronous FIFO with flush and valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic      clk,   // System clock
  input  wire logic      rst,   // Synchronous reset, high
  input  wire logic      flush, // Drops all content
  byte_stream_if.snk     fill,  // Write side
  byte_stream_if.src     drain  // Read side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;
  logic         do_wr;
  logic         do_rd;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign do_wr = fill.valid && !full;
  assign do_rd = drain.ready && !empty;

  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (rst)
    full && !do_rd && !flush |=> full)
    else $error("fifo lost content while full");

endmodule : byte_fifo

// [sim/spi_host_model.sv]
// Host controller model driving serial flash commands in mode 0
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic sys_clk,  // System clock, paces the serial clock
  output logic      sel_n,    // Chip select, low active
  output logic      spi_clk,  // Serial clock, low between frames
  output logic      spi_di,   // Serial data to the device
  input  wire logic spi_do,   // Serial data from the device
  input  wire logic spi_do_oe // Device output enable
);
  logic [7:0] rx [32];
  logic       saw_oe;

  // Idle: deselected, clock parked low
  initial begin
    sel_n   = 1'b1;
    spi_clk = 1'b0;
    spi_di  = 1'b0;
    saw_oe  = 1'b0;
  end

  // Wait falling edges, noting any driven output
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      if (spi_do_oe === 1'b1) saw_oe = 1'b1;
    end
  endtask : tick

  // One bit: data set while low, sampled just before the rise
  task automatic bit_io(input logic b, input int half, output logic q);
    spi_di = b;
    tick(half);
    // Undriven line shows the inverse, so a missing enable is caught
    q       = (spi_do_oe === 1'b1) ? spi_do : ~spi_do;
    spi_clk = 1'b1;
    tick(half);
    spi_clk = 1'b0;
  endtask : bit_io

  // Opcode, address A23 first, dummy, then nbits total; cut short freely
  task automatic xfer(input logic [7:0] op, input logic [23:0] addr,
                      input int nbits, input int half);
    logic [39:0] hdr;
    logic        q;
    int          i;
    hdr    = {op, addr, 8'ha5};
    tick(1);
    saw_oe = 1'b0;
    sel_n  = 1'b0;
    for (i = 0; i < nbits; i++) begin
      // Junk toggles on the data line once the header is out
      bit_io(i < 40 ? hdr[39-i] : ~spi_di, half, q);
      if (i >= 40 && (i - 40) / 8 < 32) rx[(i-40)/8][7-((i-40)%8)] = q;
    end
    tick(half);
    sel_n = 1'b1;
    tick(2);
  endtask : xfer
endmodule : spi_host_model

// [sim/test_sfdp_parameter_read.sv]
// Self-checking bench for the parameter-table read block
`timescale 1ns/10ps
module test_sfdp_parameter_read;
  logic sys_clk;
  logic sys_rst;
  logic flash_busy;
  logic sel_n;
  logic spi_clk;
  logic spi_di;
  logic spi_do;
  logic spi_do_oe;
  logic refused;
  int   err_total;
  int   compares;

  // Expected header table, byte address order
  localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50,
    8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00, 8'h01, 8'h09,
    8'h30, 8'h00, 8'h00, 8'hff};

  // 200 MHz clock
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  sfdp_parameter_read dut (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .sel_n      (sel_n),
    .spi_clk    (spi_clk),
    .spi_di     (spi_di),
    .flash_busy (flash_busy),
    .spi_do     (spi_do),
    .spi_do_oe  (spi_do_oe),
    .refused    (refused)
  );

  spi_host_model host (
    .sys_clk   (sys_clk),
    .sel_n     (sel_n),
    .spi_clk   (spi_clk),
    .spi_di    (spi_di),
    .spi_do    (spi_do),
    .spi_do_oe (spi_do_oe)
  );

  // Body of the basic table is out of scope and reads as fill
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    return (a < 8'h10) ? HDR[a[3:0]] : 8'hff;
  endfunction : exp_byte

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Full read of n bytes, then output must be released
  task automatic read_chk(input logic [7:0] a, input int n, input int half);
    int i;
    host.xfer(8'h5a, {16'h0000, a}, 40 + 8 * n, half);
    for (i = 0; i < n; i++) begin
      check(host.rx[i], exp_byte(a + 8'(i)));
    end
    check({7'h00, spi_do_oe}, 8'h00);
  endtask : read_chk

  task automatic t_header;
    read_chk(8'h00, 16, 3);
    $display("header table read done");
  endtask : t_header

  // Fastest legal clock across the top of the table
  task automatic t_wrap;
    read_chk(8'hfe, 4, 2);
    $display("wrap read done");
  endtask : t_wrap

  task automatic t_busy;
    flash_busy = 1'b1;
    host.xfer(8'h5a, 24'h000000, 56, 3);
    check({7'h00, host.saw_oe}, 8'h00);
    check({7'h00, refused}, 8'h01);
    flash_busy = 1'b0;
    read_chk(8'h08, 4, 3);
    check({7'h00, refused}, 8'h00);
    $display("busy refusal done");
  endtask : t_busy

  // Deselect mid-byte, then mid-address; both must leave clean idle
  task automatic t_abort;
    host.xfer(8'h5a, 24'h000004, 52, 3);
    check(host.rx[0], 8'h00);
    check({7'h00, spi_do_oe}, 8'h00);
    host.xfer(8'h5a, 24'h000000, 20, 3);
    check({7'h00, host.saw_oe}, 8'h00);
    read_chk(8'h0c, 4, 3);
    $display("abort handling done");
  endtask : t_abort

  task automatic t_other_op;
    host.xfer(8'h03, 24'h000000, 56, 3);
    check({7'h00, host.saw_oe}, 8'h00);
    check({7'h00, refused}, 8'h00);
    $display("foreign opcode done");
  endtask : t_other_op

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence; inputs change on the falling edge
  initial begin
    err_total  = 0;
    compares   = 0;
    sys_rst    = 1'b1;
    flash_busy = 1'b0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_header;
    t_wrap;
    t_busy;
    t_abort;
    t_other_op;
    tally_and_finish;
  end

  // Tests need under 10k cycles; allow ample margin
  initial begin
    #150000;
    err_total++;
    $display("[ERR] t=%0t seen=%h want=%h", $time, 8'h00, 8'h01);
    tally_and_finish;
  end
endmodule : test_sfdp_parameter_read
